// ### port9_top.sv
/*
  Five-bit bidirectional port: data latch, direction register, readback.
  Assumes a single-cycle register port and synchronous pin inputs.
*/
`timescale 1ns/1ns
module port9_top
  import port9_pkg::*;
#(
  parameter bit FLASH_VARIANT = 1'b0
)
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_resetn,
  input  wire logic [15:0]            i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic [7:0]                  o_rdata,
  input  wire port9_pkg::power_mode_t i_power_mode,
  input  wire logic [4:0]             i_port_pin,
  output logic [4:0]                  o_port_pin,
  output logic [4:0]                  o_port_pin_oe
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [4:0] port_data_latch;
  logic [4:0] port_direction_control;
  logic [4:0] next_data_latch;
  logic [4:0] next_direction;
  logic [7:0] next_rdata;
  logic [4:0] usable_mask;
  logic [4:0] pin_mix;

  // Flash variant loses pin 0 to the programming supply
  assign usable_mask = FLASH_VARIANT ? 5'h1_e : 5'h1_f;

  always_comb begin
    next_data_latch = port_data_latch;
    next_direction  = port_direction_control;
    if (i_wr && i_addr == ADDR_DATA_LATCH) begin
      next_data_latch = i_wdata[PIN_MSB:0] & usable_mask;
    end
    if (i_wr && i_addr == ADDR_DIRECTION) begin
      next_direction = i_wdata[PIN_MSB:0] & usable_mask;
    end
  end

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < PIN_COUNT; g++) begin : g_mix
      assign pin_mix[g] = port_direction_control[g] ? port_data_latch[g]
                                                   : i_port_pin[g];
    end
  endgenerate

  always_comb begin
    next_rdata = 8'h0_0;
    if (i_rd) begin
      if (i_addr == ADDR_DATA_LATCH) begin
        // Bits 7:6 ones, bit 5 zero, masked pin 0 for flash
        next_rdata = RESERVED_ONES | {3'b000, pin_mix & usable_mask};
      end else if (i_addr == ADDR_DIRECTION) begin
        next_rdata = DIRECTION_READ;
      end else begin
        next_rdata = UNMAPPED_READ;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      port_data_latch        <= DATA_LATCH_RESET[PIN_MSB:0];
      port_direction_control <= DIRECTION_RESET[PIN_MSB:0];
      o_rdata                <= 8'h0_0;
    end else begin
      port_data_latch        <= next_data_latch;
      port_direction_control <= next_direction;
      o_rdata                <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  port9_pin_gate u_gate (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_mode    (i_power_mode),
    .i_out_val (port_data_latch),
    .i_out_en  (port_direction_control),
    .o_pin_out (o_port_pin),
    .o_pin_oe  (o_port_pin_oe)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_res_bits;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd && i_addr == ADDR_DATA_LATCH) |=> (o_rdata[7:5] == 3'b110);
  endproperty
  a_res_bits: assert property (p_res_bits) else $error("reserved bits wrong");

  property p_bit5;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd && i_addr == ADDR_DATA_LATCH) |=> !o_rdata[5];
  endproperty
  a_bit5: assert property (p_bit5) else $error("bit 5 not zero");

  property p_dir_read;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd && i_addr == ADDR_DIRECTION) |=> (o_rdata == 8'hff);
  endproperty
  a_dir_read: assert property (p_dir_read) else $error("direction read not all ones");

  property p_out_read;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd && i_addr == ADDR_DATA_LATCH && port_direction_control[4]) |=>
        (o_rdata[4] == $past(port_data_latch[4]));
  endproperty
  a_out_read: assert property (p_out_read) else $error("output pin read not latch");

  property p_in_read;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_rd && i_addr == ADDR_DATA_LATCH && !port_direction_control[3]) |=>
        (o_rdata[3] == $past(i_port_pin[3]));
  endproperty
  a_in_read: assert property (p_in_read) else $error("input pin read not level");

  property p_write_latch;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_wr && i_addr == ADDR_DATA_LATCH) |=>
        (port_data_latch[4:1] == $past(i_wdata[4:1]));
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch write lost");

  property p_write_dir;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_wr && i_addr == ADDR_DIRECTION && i_power_mode == MODE_ACTIVE) |=> ##1
        (o_port_pin_oe[4:1] == $past(i_wdata[4:1], 2));
  endproperty
  a_write_dir: assert property (p_write_dir) else $error("direction not applied");

  property p_flash_bit0;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (FLASH_VARIANT && i_rd && i_addr == ADDR_DATA_LATCH) |=> !o_rdata[0];
  endproperty
  a_flash_bit0: assert property (p_flash_bit0) else $error("flash bit 0 not zero");

  c_out_read:  cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_rd && i_addr == ADDR_DATA_LATCH && port_direction_control != 5'h0_0);
  c_dir_write: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_wr && i_addr == ADDR_DIRECTION);
  c_sleep:     cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_power_mode == MODE_SLEEP && o_port_pin_oe != 5'h0_0);

endmodule

// ### port9_pkg.sv
/*
  Constants, register map and power-mode codes for the five-bit I/O port.
  Assumes a byte-wide register port driven by the CPU on i_sys_clk.
*/
// How it works
// - Data latch is 8 bits; bits 4..0 drive the five pins.
// - Output-direction bits read back the stored latch value.
// - Input-direction bits read back the sampled pin level.
// - Latch bits 7 and 6 read 1 and ignore writes.
// - Latch bit 5 reads 0 and ignores writes.
// - Flash variant: latch bit 0 reads 0, ignores writes.
// - Latch resets to 0xC0.
// - Direction bit 1 makes the pin output, 0 makes it input.
// - Direction register is write-only and reads as all ones.
// - Direction register resets to 0xC0, all pins input.
// - Pins float in reset/standby, hold in sleep/watch, work in active.
package port9_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_DATA_LATCH = 16'hffdc;
  localparam logic [15:0] ADDR_DIRECTION  = 16'hffec;

  localparam logic [7:0]  DATA_LATCH_RESET = 8'hc0;
  localparam logic [7:0]  DIRECTION_RESET  = 8'hc0;
  localparam logic [7:0]  RESERVED_ONES    = 8'hc0;
  localparam logic [7:0]  DIRECTION_READ   = 8'hff;
  localparam logic [7:0]  UNMAPPED_READ    = 8'h00;

  localparam int          PIN_COUNT  = 5;
  localparam int          PIN_MSB    = 4;
  localparam int          FLASH_PIN  = 0;

  // ----------------------------------------------------------------
  // Operating modes from the power controller
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_ACTIVE    = 3'b000,
    MODE_SUBACTIVE = 3'b001,
    MODE_SLEEP     = 3'b010,
    MODE_SUBSLEEP  = 3'b011,
    MODE_WATCH     = 3'b100,
    MODE_STANDBY   = 3'b101
  } power_mode_t;

  typedef enum logic [1:0] {
    DRIVE_FLOAT  = 2'b00,
    DRIVE_HOLD   = 2'b01,
    DRIVE_NORMAL = 2'b10
  } drive_state_t;

endpackage

// ### port9_pin_gate.sv
/*
  Pin driver gate: turns the power mode into float, hold or normal drive.
  Assumes mode codes come from the power controller on the same clock.
*/
`timescale 1ns/1ns
module port9_pin_gate
  import port9_pkg::*;
(
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_resetn,
  input  wire port9_pkg::power_mode_t i_mode,
  input  wire logic [4:0]           i_out_val,
  input  wire logic [4:0]           i_out_en,
  output logic [4:0]                o_pin_out,
  output logic [4:0]                o_pin_oe
);

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  function automatic drive_state_t drive_of(input power_mode_t m);
    drive_state_t d;
    d = DRIVE_FLOAT;
    unique case (m)
      MODE_ACTIVE, MODE_SUBACTIVE:            d = DRIVE_NORMAL;
      MODE_SLEEP, MODE_SUBSLEEP, MODE_WATCH:  d = DRIVE_HOLD;
      default:                                d = DRIVE_FLOAT;
    endcase
    return d;
  endfunction

  drive_state_t drive;
  logic [4:0]   next_pin_out;
  logic [4:0]   next_pin_oe;

  assign drive = drive_of(i_mode);

  always_comb begin
    next_pin_out = o_pin_out;
    next_pin_oe  = o_pin_oe;
    unique case (drive)
      DRIVE_NORMAL: begin
        next_pin_out = i_out_val;
        next_pin_oe  = i_out_en;
      end
      DRIVE_HOLD: begin
        next_pin_out = o_pin_out;
        next_pin_oe  = o_pin_oe;
      end
      default: begin
        next_pin_out = 5'h0_0;
        next_pin_oe  = 5'h0_0;
      end
    endcase
  end

  // Reset floats the pins regardless of mode
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pin_out <= 5'h0_0;
      o_pin_oe  <= 5'h0_0;
    end else begin
      o_pin_out <= next_pin_out;
      o_pin_oe  <= next_pin_oe;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_float_standby;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_mode == MODE_STANDBY) |=> (o_pin_oe == 5'h0_0);
  endproperty
  a_float_standby: assert property (p_float_standby) else $error("pins driven in standby");

  property p_hold_sleep;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_mode == MODE_SLEEP || i_mode == MODE_WATCH) |=>
        (o_pin_oe == $past(o_pin_oe) && o_pin_out == $past(o_pin_out));
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("pins changed in retain mode");

  property p_normal_follow;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_mode == MODE_ACTIVE) |=> (o_pin_oe == $past(i_out_en));
  endproperty
  a_normal_follow: assert property (p_normal_follow) else $error("enable not followed");

endmodule

// ### board_model.sv
/*
  Board-side model of the five port pins: a fixed level on each pin.
  Assumes a high enable means the port itself drives that pin.
*/
`timescale 1ns/1ns
module board_model (
  input  wire logic [4:0] i_drive,
  input  wire logic [4:0] i_oe,
  input  wire logic [4:0] i_ext,
  output logic [4:0]      o_level
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Port wins where enabled, board level elsewhere
  always_comb begin
    for (int n = 0; n < 5; n++) begin
      o_level[n] = i_oe[n] ? i_drive[n] : i_ext[n];
    end
  end
endmodule

// ### tb.sv
/*
  Self-checking bench for the five-bit port and its flash variant.
  Assumes board_model resolves the pins and one system clock.
*/
`timescale 1ns/1ns
module tb;
  import port9_pkg::*;
  logic        i_sys_clk    = 1'b0;
  logic        i_resetn     = 1'b0;
  logic [15:0] i_addr       = 16'h0000;
  logic [7:0]  i_wdata      = 8'h00;
  logic        i_wr         = 1'b0;
  logic        i_rd         = 1'b0;
  power_mode_t i_power_mode = MODE_ACTIVE;
  logic [4:0]  ext          = 5'h0a;
  logic [4:0]  level;
  logic [4:0]  o_port_pin;
  logic [4:0]  o_port_pin_oe;
  logic [7:0]  o_rdata;
  logic [7:0]  flash_rdata;
  logic [7:0]  rd_main;
  logic [7:0]  rd_flash;
  int          failures     = 0;
  int          n_checks     = 0;

  always #4 i_sys_clk = ~i_sys_clk;

  port9_top port9_top_i (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_power_mode(i_power_mode), .i_port_pin(level), .o_port_pin(o_port_pin),
    .o_port_pin_oe(o_port_pin_oe));
  // Flash pins tied high so a forced-zero bit 0 stands out
  port9_top #(.FLASH_VARIANT(1'b1)) port9_top_flash_i (.i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(flash_rdata), .i_power_mode(i_power_mode), .i_port_pin(5'h1f),
    .o_port_pin(), .o_port_pin_oe());
  board_model board_model_i (.i_drive(o_port_pin), .i_oe(o_port_pin_oe), .i_ext(ext),
    .o_level(level));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    rd_main  = o_rdata;
    rd_flash = flash_rdata;
  endtask
  task automatic settle();
    repeat (3) @(posedge i_sys_clk);
    #1;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_values();
    rd(ADDR_DATA_LATCH);
    chk(rd_main, 8'hca);
    rd(ADDR_DIRECTION);
    chk(rd_main, 8'hff);
    rd(16'hffdd);
    chk(rd_main, 8'h00);
    chk(o_port_pin_oe, 5'h00);
  endtask
  task automatic t_mixed_dir();
    wr(ADDR_DIRECTION, 8'h05);
    wr(ADDR_DATA_LATCH, 8'h1f);
    settle();
    chk(o_port_pin_oe, 5'h05);
    chk(level, 5'h0f);
    rd(ADDR_DATA_LATCH);
    chk(rd_main, 8'hcf);
    chk(rd_flash, 8'hde);
  endtask
  task automatic t_reserved();
    wr(ADDR_DIRECTION, 8'hff);
    wr(ADDR_DATA_LATCH, 8'h35);
    rd(ADDR_DATA_LATCH);
    chk(rd_main, 8'hd5);
    chk(rd_flash, 8'hd4);
    rd(ADDR_DIRECTION);
    chk(rd_main, 8'hff);
  endtask
  task automatic t_power_modes();
    power_mode_t modes [6] = '{MODE_ACTIVE, MODE_SUBACTIVE, MODE_SLEEP,
                               MODE_SUBSLEEP, MODE_WATCH, MODE_STANDBY};
    logic [4:0] exp_out [6] = '{5'h0a, 5'h0a, 5'h15, 5'h15, 5'h15, 5'h00};
    logic [4:0] exp_oe [6] = '{5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h1f, 5'h00};
    for (int m = 0; m < 6; m++) begin
      @(posedge i_sys_clk);
      i_power_mode <= modes[m];
      wr(ADDR_DATA_LATCH, 8'h0a);
      settle();
      chk(o_port_pin, exp_out[m]);
      chk(o_port_pin_oe, exp_oe[m]);
      rd(ADDR_DATA_LATCH);
      chk(rd_main, 8'hca);
      @(posedge i_sys_clk);
      i_power_mode <= MODE_ACTIVE;
      wr(ADDR_DATA_LATCH, 8'h15);
      settle();
    end
  endtask
  task automatic t_mid_reset();
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    #1;
    chk(o_port_pin_oe, 5'h00);
    chk(o_port_pin, 5'h00);
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    rd(ADDR_DATA_LATCH);
    chk(rd_main, 8'hca);
  endtask

  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    t_reset_values();
    t_mixed_dir();
    t_reserved();
    t_power_modes();
    t_mid_reset();
    give_verdict();
  end
  // About 115 cycles of work; far longer means a hang
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
endmodule
